//--- hdl/osg_gearbox.sv
// Output gearbox: three-stage parallel-to-serial pipeline
`timescale 1ns/1ps
module osg_gearbox (
    input wire logic clk_sys,
    input wire logic rst,
    input wire osg_pkg::osg_mode_t mode,
    input wire logic [osg_pkg::WORD_W-1:0] data_in,
    output logic word_take,
    output osg_pkg::osg_serial_t serial_out
);
    import osg_pkg::*;

    osg_mode_t mode_reg;
    osg_mode_t next_mode_reg;
    logic [2:0] phase;
    logic [2:0] next_phase;
    logic next_word_take;
    logic load_tick;
    logic [WORD_W-1:0] stage1;
    logic [WORD_W-1:0] stage2;
    logic [WORD_W-1:0] stage3;
    logic [WORD_W-1:0] next_stage3;
    osg_serial_t next_serial;
    logic stage2_load;

    // Word period length follows the selected use
    function automatic logic [2:0] last_of(input osg_mode_t m);
        logic [2:0] r;
        case (m)
            seven_to_one_mode: r = LAST_SEVEN;
            four_to_one_mode: r = LAST_FOUR;
            default: r = LAST_EIGHT;
        endcase
        return r;
    endfunction : last_of

    // Slow word clock as a phase count on the edge clock; one clock only,
    // so the two domains stay related by construction
    always_comb begin
        load_tick = (phase == last_of(mode_reg));
        next_phase = load_tick ? PHASE_RST : 3'(phase + 3'h1);
        // Mode changes only at a word boundary [R1]
        next_mode_reg = load_tick ? mode : mode_reg;
        next_word_take = (next_phase == last_of(next_mode_reg));
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            phase <= PHASE_RST;
            mode_reg <= eight_to_one_mode;
            word_take <= 1'b0;
        end else begin
            phase <= next_phase;
            mode_reg <= next_mode_reg;
            word_take <= next_word_take;
        end
    end

    // Stage one samples the core word on the slow edge [R3] [R6]
    osg_pipe_reg #(.W(WORD_W)) u_stage1 (
        .clk_sys(clk_sys),
        .rst(rst),
        .load(load_tick),
        .d(data_in),
        .q(stage1)
    );

    // Stage two: handed over one edge after capture, so stage three can
    // reload at the next boundary without racing stage one [R4] [R6]
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            stage2_load <= 1'b0;
        end else begin
            stage2_load <= load_tick;
        end
    end

    osg_pipe_reg #(.W(WORD_W)) u_stage2 (
        .clk_sys(clk_sys),
        .rst(rst),
        .load(stage2_load),
        .d(stage1),
        .q(stage2)
    );

    // Stage three: load at the boundary, then shift LSB first per lane
    always_comb begin
        if (load_tick) begin
            next_stage3 = stage2;
            if (mode_reg == seven_to_one_mode) begin
                next_stage3[SEVEN_PAD_BIT] = 1'b0; // Bit 7 unused [R2]
            end
        end else if (mode_reg == four_to_one_mode) begin
            // Two independent nibble shifters [R1] [R2]
            next_stage3 = {1'b0, stage3[7:5], 1'b0, stage3[3:1]};
        end else begin
            next_stage3 = {1'b0, stage3[7:1]}; // [R5]
        end
        next_serial.lower_io_logic_cell = next_stage3[LOWER_LSB];
        // Upper cell only carries data in the split use
        next_serial.upper_io_logic_cell =
            (mode_reg == four_to_one_mode) && next_stage3[UPPER_LSB];
    end

    // Output flop is the tail of stage three; reset holds it low [R7]
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            stage3 <= WORD_RST;
            serial_out <= SERIAL_RST;
        end else begin
            stage3 <= next_stage3;
            serial_out <= next_serial;
        end
    end

    // Checks on the pipeline
    sequence s_take_eight;
        word_take && mode_reg == eight_to_one_mode
            && mode == eight_to_one_mode;
    endsequence

    sequence s_first_bits;
        (serial_out.lower_io_logic_cell == $past(stage2[0]))
            ##1 (serial_out.lower_io_logic_cell == $past(stage2[1], 2));
    endsequence

    // Same use on both sides of the boundary, so load and shift agree
    sequence s_take_seven;
        word_take && mode_reg == seven_to_one_mode
            && mode == seven_to_one_mode;
    endsequence

    sequence s_take_four;
        word_take && mode_reg == four_to_one_mode
            && mode == four_to_one_mode;
    endsequence

    // Take stays low for the rest of the period, then returns once
    sequence s_gap_eight;
        !word_take [*7] ##1 word_take;
    endsequence

    sequence s_gap_seven;
        !word_take [*6] ##1 word_take;
    endsequence

    sequence s_gap_four;
        !word_take [*3] ##1 word_take;
    endsequence

    // Both nibbles leave LSB first in the same cycles
    sequence s_nibbles_out;
        (serial_out == {$past(stage2[4]), $past(stage2[0])})
            ##1 (serial_out == {$past(stage2[5], 2), $past(stage2[1], 2)})
            ##1 (serial_out == {$past(stage2[6], 3), $past(stage2[2], 3)})
            ##1 (serial_out == {$past(stage2[7], 4), $past(stage2[3], 4)});
    endsequence

    a_take_on_phase: assert property ( // [R3]
        @(posedge clk_sys) disable iff (rst)
        (word_take && mode == eight_to_one_mode) |=> s_gap_eight)
        else $error("word period wrong in eight-to-one use");

    // Period follows the use sampled at the take
    a_period_seven: assert property ( // [R1]
        @(posedge clk_sys) disable iff (rst)
        (word_take && mode == seven_to_one_mode) |=> s_gap_seven)
        else $error("word period wrong in seven-to-one use");

    a_period_four: assert property ( // [R1]
        @(posedge clk_sys) disable iff (rst)
        (word_take && mode == four_to_one_mode) |=> s_gap_four)
        else $error("word period wrong in split use");

    a_stage1_capture: assert property ( // [R3]
        @(posedge clk_sys) disable iff (rst)
        word_take |=> stage1 == $past(data_in))
        else $error("stage one missed the core word");

    a_stage2_handover: assert property ( // [R4]
        @(posedge clk_sys) disable iff (rst)
        word_take |=> ##1 (stage2 == $past(stage1)))
        else $error("stage two did not take stage one");

    a_stage3_shift: assert property ( // [R5]
        @(posedge clk_sys) disable iff (rst)
        s_take_eight |=> s_first_bits)
        else $error("serial bits out of order");

    a_three_stage_latency: assert property ( // [R6]
        @(posedge clk_sys) disable iff (rst)
        s_take_eight |-> ##9
        (serial_out.lower_io_logic_cell == $past(data_in[0], 9)))
        else $error("word did not reach output after three stages");

    a_seven_pad_low: assert property ( // [R2]
        @(posedge clk_sys) disable iff (rst)
        (word_take && mode_reg == seven_to_one_mode) |=>
        stage3[SEVEN_PAD_BIT] == 1'b0)
        else $error("bit 7 leaked in seven-to-one use");

    a_pair_upper_lane: assert property ( // [R1]
        @(posedge clk_sys) disable iff (rst)
        (word_take && mode_reg == four_to_one_mode) |=>
        serial_out.upper_io_logic_cell == $past(stage2[UPPER_LSB]))
        else $error("upper lane did not carry bit 4 first");

    a_upper_quiet: assert property ( // [R2]
        @(posedge clk_sys) disable iff (rst)
        $past(mode_reg) != four_to_one_mode
        |-> !serial_out.upper_io_logic_cell)
        else $error("upper lane active outside split use");

    a_nibble_pair: assert property ( // [R2]
        @(posedge clk_sys) disable iff (rst)
        s_take_four |=> s_nibbles_out)
        else $error("nibble lanes out of order");

    // Bit 6 is the last one out; bit 7 never reaches the pin
    a_seven_last_bit: assert property ( // [R5]
        @(posedge clk_sys) disable iff (rst)
        s_take_seven |-> ##7
        (serial_out.lower_io_logic_cell == $past(stage2[6], 7)))
        else $error("bit 6 not last in seven-to-one use");

    // Second reset edge onward: the first edge may still see power-up X
    a_reset_low: assert property ( // [R7]
        @(posedge clk_sys)
        (rst && $past(rst)) |-> (serial_out == SERIAL_RST
        && stage1 == WORD_RST
        && stage2 == WORD_RST && stage3 == WORD_RST && !word_take))
        else $error("reset did not clear the pipeline");

endmodule : osg_gearbox

//--- hdl/osg_pkg.sv
// Package: constants, modes and carrier types of the output gearbox
// Behaviour
// R1: Gearbox runs as seven-to-one, eight-to-one, or two independent four-to-one.
// R2: Word is eight bits; 7:1 uses 6..0, 4:1 pair splits 3..0 / 7..4.
// R3: First stage captures the core word on the slow word clock edge.
// R4: Second stage moves the captured word into the fast-clock registers.
// R5: Third stage shifts bits out one after another on the serial output.
// R6: Exactly three register stages sit between parallel input and output.
// R7: Reset clears all three stages and holds the serial output low.
package osg_pkg;

    // Word width and lane positions
    localparam int WORD_W = 8;
    localparam int LOWER_LSB = 0;
    localparam int UPPER_LSB = 4;
    localparam int SEVEN_PAD_BIT = 7;

    // Last phase of one word period, per mode (bits per lane per word minus one)
    localparam logic [2:0] LAST_SEVEN = 3'h6;
    localparam logic [2:0] LAST_EIGHT = 3'h7;
    localparam logic [2:0] LAST_FOUR = 3'h3;

    // Values after reset
    localparam logic [2:0] PHASE_RST = 3'h0;
    localparam logic [WORD_W-1:0] WORD_RST = 8'h00;

    // Cycles from the word-take cycle to its first serial bit, eight mode
    localparam int EIGHT_LATENCY = 9;

    // Gearbox uses
    typedef enum logic [1:0] {
        seven_to_one_mode,
        eight_to_one_mode,
        four_to_one_mode
    } osg_mode_t;

    // Serial outputs toward the output buffers
    typedef struct packed {
        logic upper_io_logic_cell;
        logic lower_io_logic_cell;
    } osg_serial_t;

    localparam osg_serial_t SERIAL_RST = 2'b00;

endpackage : osg_pkg

//--- hdl/osg_pipe_reg.sv
// Loadable word register used for the first two pipeline stages
`timescale 1ns/1ps
module osg_pipe_reg #(
    parameter int W = 8
) (
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic load,
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);
    logic [W-1:0] next_q;

    // Hold unless loaded
    always_comb begin
        next_q = load ? d : q;
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            q <= '0;
        end else begin
            q <= next_q;
        end
    end

endmodule : osg_pipe_reg

//--- testbench/osg_core_model.sv
// Core-side word source that feeds the output gearbox
`timescale 1ns/1ps
module osg_core_model (
    input wire logic word_take,
    input wire logic [osg_pkg::WORD_W-1:0] word,
    output logic [osg_pkg::WORD_W-1:0] data_in
);
    // Valid only in the take cycle; inverse elsewhere, never stale
    assign data_in = word_take ? word : ~word;
endmodule : osg_core_model

//--- testbench/tb_top.sv
// Self-checking bench for the output gearbox
`timescale 1ns/1ps
module tb_top;
    import osg_pkg::*;
    logic clk_sys = 1'b0;
    logic rst = 1'b1;
    osg_mode_t mode = eight_to_one_mode;
    logic [WORD_W-1:0] word = 8'h00;
    logic [WORD_W-1:0] data_in;
    logic word_take;
    osg_serial_t serial_out;
    int n_mismatch = 0;
    int n_checks = 0;

    // Single fast clock, 100 MHz
    initial begin
        forever #5 clk_sys = ~clk_sys;
    end

    osg_gearbox dut (.clk_sys(clk_sys), .rst(rst), .mode(mode),
        .data_in(data_in), .word_take(word_take),
        .serial_out(serial_out));
    osg_core_model core (.word_take(word_take), .word(word),
        .data_in(data_in));

    task automatic finish_test;
        if (n_mismatch == 0 && n_checks > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : finish_test

    task automatic chk(input string what, input logic [1:0] exp,
                       input logic [1:0] got);
        n_checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("wrong value %s expected %b seen %b", what, exp, got);
        end
    endtask : chk

    // Next take cycle, seen at a falling edge; bounded so a hang ends
    task automatic wait_take;
        int i;
        @(negedge clk_sys);
        for (i = 0; i < 20 && word_take !== 1'b1; i++) begin
            @(negedge clk_sys);
        end
        if (word_take !== 1'b1) begin
            n_mismatch++;
            finish_test();
        end
    endtask : wait_take

    // Two back-to-back words, LSB first; the upper lane only in four mode
    task automatic run_mode(input osg_mode_t m, input logic [7:0] w0,
                            input logic [7:0] w1);
        int n;
        logic [7:0] w;
        logic [1:0] exp;
        n = (m == seven_to_one_mode) ? 7 : (m == four_to_one_mode) ? 4 : 8;
        mode = m;
        word = w0;
        // Flush words shifted while the mode was changing
        repeat (3) wait_take();
        @(negedge clk_sys);
        word = w1;
        repeat (n - 1) @(negedge clk_sys);
        for (int i = 0; i < 2 * n; i++) begin
            @(negedge clk_sys);
            w = (i < n) ? w0 : w1;
            exp[1] = (m == four_to_one_mode) ? w[4 + i % n] : 1'b0;
            exp[0] = w[i % n];
            chk("serial_out", exp, serial_out);
        end
    endtask : run_mode

    // Reset in mid-stream clears the output at once, then restarts
    task automatic reset_check;
        mode = eight_to_one_mode;
        word = 8'hFF;
        repeat (3) wait_take();
        repeat (12) @(negedge clk_sys);
        chk("serial_out", 2'b01, serial_out);
        rst = 1'b1;
        #1;
        chk("serial_out", 2'b00, serial_out);
        chk("word_take", 2'b00, {1'b0, word_take});
        repeat (3) @(negedge clk_sys);
        rst = 1'b0;
        repeat (6) @(negedge clk_sys);
        chk("word_take", 2'b00, {1'b0, word_take});
        @(negedge clk_sys);
        chk("word_take", 2'b01, {1'b0, word_take});
        chk("serial_out", 2'b00, serial_out);
    endtask : reset_check

    // Main sequence: reset held 20 cycles, then every mode
    initial begin
        repeat (20) @(negedge clk_sys);
        chk("serial_out", 2'b00, serial_out);
        rst = 1'b0;
        run_mode(eight_to_one_mode, 8'hD3, 8'h2C);
        run_mode(seven_to_one_mode, 8'hB5, 8'h4A);
        run_mode(four_to_one_mode, 8'h9C, 8'h63);
        reset_check();
        finish_test();
    end
endmodule : tb_top
